// ### src/gpdrb_top.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module gpdrb_top
    import gpdrb_pkg::*;
(
    input  wire logic                 CLK_IN,       // 250 MHz clock
    input  wire logic                 RESET_IN,     // sync reset, high
    input  wire logic [7:0]           ADDR_IN,      // register address
    input  wire logic [7:0]           WDATA_IN,     // write data
    input  wire logic                 WR_IN,        // write strobe
    input  wire logic                 RD_IN,        // read strobe
    output logic      [7:0]           RDATA_OUT,    // read data, next cycle
    input  wire logic [NUM_SLOTS-1:0] PIN_IN,       // pin levels
    output logic      [NUM_SLOTS-1:0] PIN_OUT,      // pin drive values
    output logic      [NUM_SLOTS-1:0] PIN_OE_N_OUT  // pin drive enables, low drives
);

    ////////////////////////////////////////////////////////////////////////////
    // block state
    typedef struct packed {
        logic [7:0]                rdata;
        logic [NUM_SLOTS-1:0][7:0] cfg;
    } gpdrb_top_s;

    gpdrb_top_s               st;
    gpdrb_top_s               next_st;
    gpdrb_req_s               req;

    logic                     cfg_hit;
    logic [7:0]               cfg_off;
    logic [5:0]               cfg_idx;
    logic                     bank_hit;
    logic [7:0]               bank_off;
    logic [2:0]               bank_idx;

    logic [NUM_SLOTS-1:0]     slot_wr;
    logic [NUM_SLOTS-1:0]     slot_rd;
    logic [NUM_SLOTS-1:0]     slot_wbit;
    logic [NUM_SLOTS-1:0]     slot_rbit;
    logic [7:0]               bank_rdata;
    logic [7:0]               cfg_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // slot number of a bit in a bank
    function automatic logic [5:0] slot_of(input logic [2:0] bank, input int bitpos);
        logic [5:0] base;
        base = BANK_BASE[bank];
        return base + 6'(bitpos);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bundle the bus request
    always_comb begin
        req.addr  = ADDR_IN;
        req.wdata = WDATA_IN;
        req.wr    = WR_IN;
        req.rd    = RD_IN;
    end

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    always_comb begin
        cfg_off  = req.addr - ADDR_CFG_BASE;
        cfg_idx  = cfg_off[5:0];
        cfg_hit  = (req.addr >= ADDR_CFG_BASE) && (req.addr <= ADDR_CFG_LAST)
                   && (cfg_idx != 6'(RSVD_SLOT));
        bank_off = req.addr - ADDR_BANK_ONE;
        bank_idx = bank_off[2:0];
        bank_hit = (req.addr >= ADDR_BANK_ONE)
                   && (req.addr <= ADDR_BANK_SIX);
    end

    ////////////////////////////////////////////////////////////////////////////
    // fan the data register access out to the pins
    always_comb begin
        slot_wr   = '0;
        slot_rd   = '0;
        slot_wbit = '0;
        for (int b = 0; b < NUM_BANKS; b++) begin
            for (int i = 0; i < BANK_BITS; i++) begin
                if (BANK_MASK[b][i]) begin
                    if (bank_hit && (bank_idx == 3'(b))) begin
                        slot_wr[slot_of(3'(b), i)]   = req.wr;
                        slot_rd[slot_of(3'(b), i)]   = req.rd;
                        slot_wbit[slot_of(3'(b), i)] = req.wdata[i];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assemble the addressed data register
    always_comb begin
        bank_rdata = '0;
        for (int b = 0; b < NUM_BANKS; b++) begin
            for (int i = 0; i < BANK_BITS; i++) begin
                if (BANK_MASK[b][i] && (bank_idx == 3'(b))) begin
                    bank_rdata[i] = slot_rbit[slot_of(3'(b), i)];
                end
            end
        end
        // bits outside the mask stay zero
    end

    ////////////////////////////////////////////////////////////////////////////
    // addressed configuration byte
    always_comb begin
        cfg_rdata = '0;
        if (cfg_hit) begin
            cfg_rdata = st.cfg[cfg_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: configuration writes and read data
    always_comb begin
        next_st       = st;
        next_st.rdata = '0;
        if (req.wr && cfg_hit) begin
            next_st.cfg[cfg_idx] = req.wdata;
        end
        if (req.rd) begin
            if (bank_hit) begin
                next_st.rdata = bank_rdata;
            end else if (cfg_hit) begin
                next_st.rdata = cfg_rdata;
            end else begin
                next_st.rdata = '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            st.rdata <= RDATA_RESET;
            for (int s = 0; s < NUM_SLOTS; s++) begin
                st.cfg[s] <= OUT_AT_RESET[s] ? CFG_RESET_OUT : CFG_RESET_IN;
            end
            st.cfg[RSVD_SLOT] <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one data latch per implemented pin
    for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
        if (s == RSVD_SLOT) begin : g_rsvd
            assign slot_rbit[s]    = 1'b0;
            assign PIN_OUT[s]      = 1'b0;
            assign PIN_OE_N_OUT[s] = 1'b1;
        end else begin : g_pin
            gpdrb_pad_s pad;

            gpdrb_pin u_pin (
                .clk_in     (CLK_IN),
                .reset_in   (RESET_IN),
                .pin_in     (PIN_IN[s]),
                .cfg_in     (st.cfg[s]),
                .wr_in      (slot_wr[s]),
                .wr_bit_in  (slot_wbit[s]),
                .rd_in      (slot_rd[s]),
                .rd_bit_out (slot_rbit[s]),
                .pad_out    (pad)
            );

            assign PIN_OUT[s]      = pad.out;
            assign PIN_OE_N_OUT[s] = pad.oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data port
    assign RDATA_OUT = st.rdata;

endmodule

// ### src/gpdrb_pkg.sv
package gpdrb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes of the bank
    localparam int NUM_BANKS  = 6;
    localparam int BANK_BITS  = 8;
    localparam int NUM_SLOTS  = 38;
    localparam int RSVD_SLOT  = 11;
    localparam int SYNC_DEPTH = 2;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ADDR_CFG_BASE   = 8'h23;
    localparam logic [7:0] ADDR_CFG_LAST   = 8'h48;
    localparam logic [7:0] ADDR_BANK_ONE   = 8'h4B;
    localparam logic [7:0] ADDR_BANK_TWO   = 8'h4C;
    localparam logic [7:0] ADDR_BANK_THREE = 8'h4D;
    localparam logic [7:0] ADDR_BANK_FOUR  = 8'h4E;
    localparam logic [7:0] ADDR_BANK_FIVE  = 8'h4F;
    localparam logic [7:0] ADDR_BANK_SIX   = 8'h50;

    ////////////////////////////////////////////////////////////////////////////
    // bank layout: first slot of each bank and its implemented bits
    localparam logic [5:0][5:0] BANK_BASE = {6'h24, 6'h1C, 6'h18, 6'h10, 6'h08, 6'h00};
    localparam logic [5:0][7:0] BANK_MASK = {8'h03, 8'hFF, 8'h0F, 8'hFF, 8'hF7, 8'hFF};

    ////////////////////////////////////////////////////////////////////////////
    // configuration byte fields
    localparam int CFG_DIR_BIT   = 0;
    localparam int CFG_POL_BIT   = 1;
    localparam int CFG_ODRAIN_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0]  CFG_RESET_IN  = 8'h01;
    localparam logic [7:0]  CFG_RESET_OUT = 8'h00;
    localparam logic [37:0] OUT_AT_RESET  = 38'h00_800C_0000;
    localparam logic [7:0]  RDATA_RESET   = 8'h00;
    localparam logic        LATCH_RESET   = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } gpdrb_req_s;

    typedef struct packed {
        logic out;
        logic oe_n;
    } gpdrb_pad_s;

endpackage

// ### src/gpdrb_pin.sv
`timescale 1ns/1ps
module gpdrb_pin
    import gpdrb_pkg::*;
(
    input  wire logic       clk_in,     // system clock
    input  wire logic       reset_in,   // sync reset, high
    input  wire logic       pin_in,     // raw pin level
    input  wire logic [7:0] cfg_in,     // configuration byte
    input  wire logic       wr_in,      // data bit write
    input  wire logic       wr_bit_in,  // written bit value
    input  wire logic       rd_in,      // data bit read
    output logic            rd_bit_out, // value a read returns
    output gpdrb_pad_s      pad_out     // pin drive
);

    typedef struct packed {
        logic [SYNC_DEPTH-1:0] sync;
        logic                  latch;
    } gpdrb_pin_s;

    gpdrb_pin_s st;
    gpdrb_pin_s next_st;
    logic       is_input;
    logic       pol;
    logic       odrain;
    logic       level;
    logic       drive;

    ////////////////////////////////////////////////////////////////////////////
    // latch update, read value and pin drive
    always_comb begin
        is_input = cfg_in[CFG_DIR_BIT];
        pol      = cfg_in[CFG_POL_BIT];
        odrain   = cfg_in[CFG_ODRAIN_BIT];
        level    = st.sync[SYNC_DEPTH-1] ^ pol;
        drive    = st.latch ^ pol;
        next_st       = st;
        next_st.sync  = {st.sync[SYNC_DEPTH-2:0], pin_in};
        if (is_input && rd_in) begin
            next_st.latch = level;
        end else if (!is_input && wr_in) begin
            next_st.latch = wr_bit_in;
        end
        // writes to an input leave the latch alone
        rd_bit_out   = is_input ? level : st.latch;
        pad_out.out  = !is_input && drive && !odrain;
        pad_out.oe_n = is_input || (odrain && drive);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st.sync  <= '0;
            st.latch <= LATCH_RESET;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ### verif/gpdrb_top_sva.sv
`timescale 1ns/1ps
module gpdrb_top_sva
    import gpdrb_pkg::*;
(
    input wire logic                 CLK_IN,       // clock
    input wire logic                 RESET_IN,     // sync reset
    input wire logic [7:0]           ADDR_IN,      // address
    input wire logic [7:0]           WDATA_IN,     // write data
    input wire logic                 WR_IN,        // write strobe
    input wire logic                 RD_IN,        // read strobe
    input wire logic [7:0]           RDATA_OUT,    // read data
    input wire logic [NUM_SLOTS-1:0] PIN_IN,       // pin levels
    input wire logic [NUM_SLOTS-1:0] PIN_OUT,      // drive values
    input wire logic [NUM_SLOTS-1:0] PIN_OE_N_OUT  // drive enables
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    logic unmapped;

    // address lies outside both the config and the bank ranges
    always_comb begin
        unmapped = (ADDR_IN < ADDR_CFG_BASE) || (ADDR_IN > ADDR_BANK_SIX) ||
                   (ADDR_IN > ADDR_CFG_LAST && ADDR_IN < ADDR_BANK_ONE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // read side
    a_rdata_idle_zero: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
        else $error("read data not zero outside read slot");
    a_unmapped_read_zero: assert property ($past(RD_IN) && $past(unmapped) |-> RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    a_bank_two_gap: assert property ($past(RD_IN) && $past(ADDR_IN) == ADDR_BANK_TWO |-> !RDATA_OUT[3])
        else $error("bank two reserved bit set");
    a_bank_four_gap: assert property ($past(RD_IN) && $past(ADDR_IN) == ADDR_BANK_FOUR |-> RDATA_OUT[7:4] == 4'h0)
        else $error("bank four reserved bits set");
    a_bank_six_gap: assert property ($past(RD_IN) && $past(ADDR_IN) == ADDR_BANK_SIX |-> RDATA_OUT[7:2] == 6'h00)
        else $error("bank six reserved bits set");
    a_cfg_gap_zero: assert property ($past(RD_IN) && $past(ADDR_IN) == 8'h2E |-> RDATA_OUT == 8'h00)
        else $error("reserved config slot not zero");

    ////////////////////////////////////////////////////////////////////////////
    // pin side
    a_out_hold_steady: assert property (!$past(WR_IN) |-> $stable(PIN_OUT) && $stable(PIN_OE_N_OUT))
        else $error("pin drive moved without a write");
    a_undriven_low: assert property ((PIN_OUT & PIN_OE_N_OUT) == '0)
        else $error("drive value high on released pin");
    a_slot_gap_off: assert property (PIN_OE_N_OUT[RSVD_SLOT] && !PIN_OUT[RSVD_SLOT])
        else $error("reserved slot driven");
endmodule

bind gpdrb_top gpdrb_top_sva u_sva (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE_N_OUT(PIN_OE_N_OUT));

// ### verif/gpdrb_board.sv
`timescale 1ns/1ps
module gpdrb_board
    import gpdrb_pkg::*;
(
    input  wire logic [NUM_SLOTS-1:0] level_in,  // board's own level
    input  wire logic [NUM_SLOTS-1:0] drive_in,  // device drive value
    input  wire logic [NUM_SLOTS-1:0] oe_n_in,   // device enable, low drives
    output logic      [NUM_SLOTS-1:0] wire_out   // resolved pin level
);
    // device wins where it drives, board level elsewhere
    assign wire_out = (oe_n_in & level_in) | (~oe_n_in & drive_in);
endmodule

// ### verif/gpdrb_tb_top.sv
`timescale 1ns/1ps
module gpdrb_tb_top;
    import gpdrb_pkg::*;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic [7:0]           addr = 8'h00;
    logic [7:0]           wdata = 8'h00;
    logic                 wr = 1'b0;
    logic                 rd = 1'b0;
    logic [7:0]           rdata;
    logic [NUM_SLOTS-1:0] pin_in;
    logic [NUM_SLOTS-1:0] pin_out;
    logic [NUM_SLOTS-1:0] pin_oe_n;
    logic [NUM_SLOTS-1:0] board_lvl = '1;
    int                   errors = 0;
    int                   n_checks = 0;
    logic [7:0]           exp_bank [6] = '{8'hFF, 8'hF7, 8'hF3, 8'h0F, 8'hF7, 8'h03};

    ////////////////////////////////////////////////////////////////////////////
    // clock, design and board
    always #2 clk = ~clk;
    gpdrb_top dut (.CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N_OUT(pin_oe_n));
    gpdrb_board u_board (.level_in(board_lvl), .drive_in(pin_out), .oe_n_in(pin_oe_n), .wire_out(pin_in));

    ////////////////////////////////////////////////////////////////////////////
    // report and bus tasks
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [37:0] e, input logic [37:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, {30'h0, e}, {30'h0, rdata});
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("oe_n reset", 38'h3F_7FF3_FFFF, pin_oe_n);
        chk("out reset", 38'h00_0000_0000, pin_out);
        rd_chk("cfg slot0", ADDR_CFG_BASE, 8'h01);
        rd_chk("cfg slot18", 8'h35, 8'h00);
        for (int b = 0; b < NUM_BANKS; b++) begin
            rd_chk("bank", ADDR_BANK_ONE + 8'(b), exp_bank[b]);
        end
        // input reads and polarity
        @(posedge clk);
        board_lvl[7:0] <= 8'hA5;
        repeat (3) @(posedge clk);
        rd_chk("in read", ADDR_BANK_ONE, 8'hA5);
        wr_reg(ADDR_CFG_BASE, 8'h03);
        rd_chk("in inverted", ADDR_BANK_ONE, 8'hA4);
        wr_reg(ADDR_BANK_ONE, 8'h00);
        rd_chk("in write", ADDR_BANK_ONE, 8'hA4);
        chk("in oe_n", 38'h3F_7FF3_FFFF, pin_oe_n);
        wr_reg(ADDR_BANK_ONE, 8'h00);
        // outputs: the latch still holds what the last read captured
        for (int s = 0; s < 8; s++) begin
            wr_reg(ADDR_CFG_BASE + 8'(s), 8'h00);
        end
        chk("latch kept", 38'h00_0000_00A4, pin_out);
        wr_reg(ADDR_BANK_ONE, 8'h3C);
        chk("out drive", 38'h00_0000_003C, pin_out);
        chk("out oe_n", 38'h3F_7FF3_FF00, pin_oe_n);
        rd_chk("out read", ADDR_BANK_ONE, 8'h3C);
        wr_reg(ADDR_CFG_BASE, 8'h02);
        chk("out inverted", 38'h00_0000_003D, pin_out);
        rd_chk("out read inv", ADDR_BANK_ONE, 8'h3C);
        rd_chk("cfg readback", 8'h24, 8'h00);
        // open drain on slot 2: a high data bit releases the pin
        wr_reg(ADDR_CFG_BASE + 8'h02, 8'h80);
        chk("odrain out", 38'h00_0000_0039, pin_out);
        chk("odrain oe_n", 38'h3F_7FF3_FF04, pin_oe_n);
        rd_chk("odrain read", ADDR_BANK_ONE, 8'h3C);
        // reserved and unmapped places
        wr_reg(8'h47, 8'h00);
        wr_reg(8'h48, 8'h00);
        wr_reg(ADDR_BANK_SIX, 8'hFF);
        rd_chk("bank six", ADDR_BANK_SIX, 8'h03);
        chk("bank six drive", 38'h30_0000_0039, pin_out);
        wr_reg(8'h2E, 8'hFF);
        rd_chk("cfg gap", 8'h2E, 8'h00);
        wr_reg(8'h49, 8'hFF);
        rd_chk("unmapped low", 8'h49, 8'h00);
        rd_chk("unmapped high", 8'h51, 8'h00);
        end_sim();
    end
endmodule
